// *** pstr_bench.sv ***
// self-checking bench for the program sequencer
// assumes pstr_top, pstr_prog_mem and pstr_properties are compiled first
`timescale 1ns/1ps
module pstr_bench;
	logic hclk;
	logic hresetn;
	logic hsel;
	logic [31:0] haddr;
	logic [1:0] htrans;
	logic hwrite;
	logic [31:0] hwdata;
	logic hreadyout;
	logic hresp;
	logic [31:0] hrdata;
	logic [9:0] prog_addr;
	logic [13:0] prog_data;
	logic [1:0] phase;
	logic [13:0] exec_word;
	logic exec_valid;
	pstr_pkg::pstr_ctl_type exec_ctl;
	pstr_pkg::pstr_tab_type table_low;
	pstr_pkg::pstr_irq_type irq_req;
	pstr_pkg::pstr_irq_type irq_ack;
	logic wake;
	int n_errors;
	int cmp_count;
	int n;
	logic [31:0] q;
	logic [31:0] w;
	logic [9:0] pa;
	logic [9:0] ra [3];
	pstr_top u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
		.hready(hreadyout), .hreadyout, .hresp, .hrdata, .prog_addr, .prog_data, .phase,
		.exec_word, .exec_valid, .exec_ctl, .table_low, .irq_req, .irq_ack, .wake);
	pstr_prog_mem u_mem (.prog_addr, .prog_data);
	initial
	begin
		hclk = 1'b0;
		forever #25 hclk = ~hclk;
	end
	task automatic stop_test;
		$display("errors %0d compares %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : stop_test
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	function automatic logic [31:0] word_at(input logic [9:0] a);
		return {18'h0, a[9:4] ^ 6'h2a, a[7:0]};
	endfunction : word_at
	// one single transfer, entered right after a rising edge
	task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= wr;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
		chk(32'(hresp), 32'h0);
	endtask : bus
	// returns one edge after the next boundary, pa holding the address fetched there
	task automatic edge_after_bnd;
		do @(posedge hclk); while (phase !== 2'h3);
		pa = prog_addr;
		exec_ctl <= '{pstr_pkg::PSTR_K_NEXT, 10'h0};
		@(posedge hclk);
	endtask : edge_after_bnd
	task automatic step(input pstr_pkg::pstr_kind_type k, input logic [9:0] t);
		do @(posedge hclk); while (phase !== 2'h2 || exec_valid !== 1'b1);
		exec_ctl <= '{k, t};
		edge_after_bnd();
	endtask : step
	task automatic wait_valid;
		n = 1;
		while (exec_valid !== 1'b1 && n < 2000)
		begin
			@(posedge hclk);
			n++;
		end
	endtask : wait_valid
	initial
	begin
		repeat (20000) @(posedge hclk);
		n_errors++;
		stop_test();
	end
	initial
	begin
		hresetn = 1'b0;
		hsel = 1'b1;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		exec_ctl = '{pstr_pkg::PSTR_K_NEXT, 10'h0};
		irq_req = 2'b00;
		wake = 1'b0;
		n_errors = 0;
		cmp_count = 0;
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		chk(32'(prog_addr), 32'h0);
		wait_valid();
		chk(32'(n >= 1024 && n < 2000), 32'h1);
		chk(32'(exec_word), word_at(10'h0));
		bus(1'b0, 32'h20, 32'h0);
		chk(q, 32'h0);
		bus(1'b1, 32'h1c, 32'hffff_ffa5);
		bus(1'b1, 32'h20, 32'hff);
		bus(1'b0, 32'h1c, 32'h0);
		chk(q, 32'ha5);
		bus(1'b0, 32'h20, 32'h0);
		chk(q, 32'h0);
		bus(1'b0, 32'h3c, 32'h0);
		chk(q, 32'h0);
		repeat (3)
		begin
			step(pstr_pkg::PSTR_K_NEXT, 10'h0);
			chk(32'(prog_addr), 32'(pa) + 32'h1);
			chk(32'(exec_word), word_at(pa));
		end
		step(pstr_pkg::PSTR_K_JUMP, 10'h2f0);
		chk(32'(prog_addr), 32'h2f0);
		chk(32'(exec_valid), 32'h0);
		step(pstr_pkg::PSTR_K_NEXT, 10'h0);
		chk(32'(pa), 32'h2f1);
		for (int i = 0; i < 3; i++)
		begin
			step(pstr_pkg::PSTR_K_CALL, 10'(i + 1) << 8);
			ra[i] = pa;
			chk(32'(prog_addr), 32'(i + 1) << 8);
		end
		bus(1'b0, 32'h44, 32'h0);
		chk(32'(q[11:10]), 32'h2);
		step(pstr_pkg::PSTR_K_RET, 10'h0);
		chk(32'(prog_addr), 32'(ra[2]));
		step(pstr_pkg::PSTR_K_RET, 10'h0);
		chk(32'(prog_addr), 32'(ra[1]));
		step(pstr_pkg::PSTR_K_SKIP, 10'h0);
		chk(32'(exec_valid), 32'h0);
		chk(32'(prog_addr), 32'(pa) + 32'h1);
		bus(1'b1, 32'h18, 32'h5a);
		edge_after_bnd();
		chk(32'(prog_addr), {22'h0, pa[9:8], 8'h5a});
		bus(1'b0, 32'h18, 32'h0);
		chk(q, 32'h5a);
		bus(1'b1, 32'h1c, 32'h3c);
		// let the short jump age out so the checkers see quiet table boundaries
		repeat (8) @(posedge hclk);
		// interrupts stay masked around the table reads
		bus(1'b0, 32'h40, 32'h0);
		chk(q, 32'h0);
		for (int i = 0; i < 2; i++)
		begin
			step(i ? pstr_pkg::PSTR_K_TAB_CUR : pstr_pkg::PSTR_K_TAB_FIN, 10'h0);
			ra[0] = i ? {pa[9:8], 8'h3c} : 10'h33c;
			chk(32'(prog_addr), 32'(ra[0]));
			n = 1;
			while (table_low.strobe !== 1'b1 && n < 9)
			begin
				@(posedge hclk);
				n++;
			end
			chk(32'(n), 32'd5);
			w = word_at(ra[0]);
			chk(32'(table_low.low), w & 32'hff);
			bus(1'b0, 32'h20, 32'h0);
			chk(q, w >> 8);
		end
		// ext, then timer, then ext again with both stack levels taken
		for (int i = 0; i < 3; i++)
		begin
			bus(1'b1, 32'h40, i == 1 ? 32'h6 : 32'h5);
			irq_req <= i == 1 ? 2'b01 : 2'b10;
			n = 0;
			while (irq_ack === 2'b00 && n < 40)
			begin
				@(posedge hclk);
				n++;
			end
			chk(32'(irq_ack), i == 2 ? 32'h0 : 32'(irq_req));
			chk(i == 2 ? 32'(prog_addr == 10'h004) : 32'(prog_addr), i == 2 ? 32'h0 : 32'h4 << i);
			irq_req <= 2'b00;
			bus(1'b0, 32'h40, 32'h0);
			chk(q, i == 2 ? 32'h5 : (i ? 32'h2 : 32'h1));
		end
		step(pstr_pkg::PSTR_K_HALT, 10'h0);
		repeat (20) @(posedge hclk);
		chk(32'(exec_valid), 32'h0);
		bus(1'b0, 32'h44, 32'h0);
		chk(32'(q[13:12]), 32'h2);
		wake <= 1'b1;
		@(posedge hclk);
		wake <= 1'b0;
		wait_valid();
		chk(32'(n >= 1024 && n < 2000), 32'h1);
		stop_test();
	end
endmodule : pstr_bench
bind pstr_top pstr_properties u_props (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready,
	.hrdata, .prog_addr, .prog_data, .phase, .exec_word, .exec_valid, .exec_ctl, .table_low,
	.irq_req, .irq_ack);

// *** pstr_cfg.svh ***
// constants of the program sequencer: register indices, vectors, reset values, timing
// assumes it is included by its bare name wherever these values are needed
`ifndef PSTR_CFG_SVH
`define PSTR_CFG_SVH

// register indices; byte address on the bus is four times the index
`define PSTR_IDX_JUMP_LOW 10'h006
`define PSTR_IDX_LOOKUP_PTR 10'h007
`define PSTR_IDX_UPPER_LATCH 10'h008
`define PSTR_IDX_CTRL 10'h010
`define PSTR_IDX_STATUS 10'h011

// control register fields
`define PSTR_CTRL_EXT_EN 0
`define PSTR_CTRL_TMR_EN 1
`define PSTR_CTRL_MASTER_EN 2
`define PSTR_CTRL_RST 3'h0

// status register fields
`define PSTR_STAT_DEPTH_LSB 10
`define PSTR_STAT_RUNNING 12
`define PSTR_STAT_HALTED 13

// program counter loads
`define PSTR_VEC_RESET 10'h000
`define PSTR_VEC_EXT 10'h004
`define PSTR_VEC_TMR 10'h008
`define PSTR_FINAL_PAGE 2'h3
`define PSTR_STACK_LEVELS 2'h2

// reset values
`define PSTR_RST_PTR 8'h00
`define PSTR_RST_UPPER 8'h00
`define PSTR_RST_WORD 14'h0000

// timing: four system clocks per instruction cycle, start-up of 1024 clock periods
`define PSTR_LAST_PHASE 2'h3
`define PSTR_SST_PERIODS 11'h400

`endif

// *** pstr_pkg.sv ***
// types shared by the program sequencer and its neighbours
// assumes pstr_cfg.svh supplies the numeric constants
package pstr_pkg;

	// what the executing instruction asks of the sequencer
	typedef enum logic [2:0] {
		PSTR_K_NEXT,
		PSTR_K_SKIP,
		PSTR_K_JUMP,
		PSTR_K_CALL,
		PSTR_K_RET,
		PSTR_K_TAB_CUR,
		PSTR_K_TAB_FIN,
		PSTR_K_HALT
	} pstr_kind_type;

	typedef struct packed {
		pstr_kind_type kind;
		logic [9:0] target;
	} pstr_ctl_type;

	typedef struct packed {
		logic strobe;
		logic [7:0] low;
	} pstr_tab_type;

	typedef struct packed {
		logic ext;
		logic tmr;
	} pstr_irq_type;

	typedef enum logic [1:0] {
		PSTR_S_START,
		PSTR_S_RUN,
		PSTR_S_TABLE,
		PSTR_S_HALT
	} pstr_state_type;

endpackage : pstr_pkg

// *** pstr_prog_mem.sv ***
// program memory model with a fixed pattern, answering at once
// assumes the sequencer samples prog_data at its boundary edge
`timescale 1ns/1ps
module pstr_prog_mem (
	// fetch port
	input wire logic [9:0] prog_addr,
	output logic [13:0] prog_data
);
	// every one of the 1024 addresses gives a distinct word
	assign prog_data = {prog_addr[9:4] ^ 6'h2a, prog_addr[7:0]};
endmodule : pstr_prog_mem

// *** pstr_properties.sv ***
// port checker for the program sequencer
// assumes it is bound to pstr_top and sees only that module's ports
`timescale 1ns/1ps
module pstr_properties (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// bus
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	// sequencer
	input wire logic [9:0] prog_addr,
	input wire logic [13:0] prog_data,
	input wire logic [1:0] phase,
	input wire logic [13:0] exec_word,
	input wire logic exec_valid,
	input wire pstr_pkg::pstr_ctl_type exec_ctl,
	input wire pstr_pkg::pstr_tab_type table_low,
	input wire pstr_pkg::pstr_irq_type irq_req,
	input wire pstr_pkg::pstr_irq_type irq_ack
);
	logic [3:0] jl_age_r;
	logic [3:0] jl_age_nxt;
	logic [10:0] up_cnt_r;
	logic [10:0] up_cnt_nxt;
	logic bnd;
	logic quiet;
	logic [9:0] tgt;
	assign bnd = phase == 2'h3 && exec_valid;
	// no short jump pending and no request that could pre-empt
	assign quiet = jl_age_r == 4'hf && irq_req == 2'b00;
	assign tgt = exec_ctl.target;
	always_comb
	begin
		jl_age_nxt = jl_age_r + {3'h0, jl_age_r != 4'hf};
		if (hsel && htrans[1] && hready && hwrite && haddr == 32'h18)
			jl_age_nxt = 4'h0;
		up_cnt_nxt = up_cnt_r + {10'h0, up_cnt_r != 11'h7ff};
	end
	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn)
		begin
			jl_age_r <= 4'h0;
			up_cnt_r <= 11'h0;
		end
		else
		begin
			jl_age_r <= jl_age_nxt;
			up_cnt_r <= up_cnt_nxt;
		end
	default clocking @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	phase_step_a: assert property (phase != 2'h0 |=> phase == $past(phase) + 2'h1)
		else $error("phase did not advance");
	next_fetch_a: assert property (bnd && exec_ctl.kind == pstr_pkg::PSTR_K_NEXT && quiet
		|=> exec_valid && prog_addr == $past(prog_addr) + 10'h1 && exec_word == $past(prog_data))
		else $error("sequential fetch wrong");
	skip_drop_a: assert property (bnd && exec_ctl.kind == pstr_pkg::PSTR_K_SKIP && quiet
		|=> !exec_valid && prog_addr == $past(prog_addr) + 10'h1)
		else $error("skip wrong");
	jump_load_a: assert property (bnd && quiet && (exec_ctl.kind == pstr_pkg::PSTR_K_JUMP
		|| exec_ctl.kind == pstr_pkg::PSTR_K_CALL) |=> !exec_valid && prog_addr == $past(tgt)
		##4 exec_valid)
		else $error("jump load wrong");
	final_page_a: assert property (bnd && exec_ctl.kind == pstr_pkg::PSTR_K_TAB_FIN && quiet
		|=> prog_addr[9:8] == 2'h3 && !exec_valid ##1 $stable(prog_addr) [*3]
		##1 table_low.strobe && exec_valid)
		else $error("final page read wrong");
	cur_page_a: assert property (bnd && exec_ctl.kind == pstr_pkg::PSTR_K_TAB_CUR && quiet
		|=> (prog_addr >> 8) == ($past(prog_addr) >> 8))
		else $error("current page read wrong");
	strobe_time_a: assert property (table_low.strobe
		|-> phase == 2'h0 && exec_valid && $past(phase) == 2'h3)
		else $error("table strobe misplaced");
	ext_vector_a: assert property (irq_ack.ext
		|-> prog_addr == 10'h004 && !exec_valid && !irq_ack.tmr)
		else $error("external vector wrong");
	tmr_vector_a: assert property (irq_ack.tmr |-> prog_addr == 10'h008 && !exec_valid)
		else $error("timer vector wrong");
	upper_zero_a: assert property (hsel && htrans[1] && hready && !hwrite && haddr == 32'h20
		|=> hrdata[31:6] == 26'h0)
		else $error("upper latch top bits set");
	startup_hold_a: assert property (up_cnt_r < 11'h3f0
		|-> prog_addr == 10'h000 && phase == 2'h0 && !exec_valid)
		else $error("ran during start-up");
endmodule : pstr_properties

// *** pstr_top.sv ***
// program sequencer with table read, ahb-lite register slave
// assumes program memory answers combinationally on prog_data for prog_addr,
// and the core presents exec_ctl for the word on exec_word through its cycle
//
// Operation
// - system clock divided into four phases; one instruction cycle is four clocks
// - a word is fetched in one cycle and executed in the next
// - any counter change costs a dummy cycle replacing the prefetched word
// - instruction address counter is 10 bits, 1024 words
// - counter advances by one after every fetch except at halt, which keeps it to refetch the discarded word
// - true skip discards the prefetched word, dummy cycle in its place
// - writing jump low byte replaces counter bits 7..0, keeps bits 9..8
// - 14-bit program memory addressed by counter or by lookup pointer
// - reset loads counter with zero
// - external request, enabled, stack not full vectors to 004H
// - timer overflow request, enabled, stack not full vectors to 008H
// - jump and call load ten bits from instruction; return from stack top
// - current-page table read uses counter bits 9..8; final-page uses last page
// - table read gives low byte to data location, upper bits to latch
// - upper latch is read-only, top two bits read zero
// - lookup pointer is read/write; software loads it before a table read
// - every table read takes two instruction cycles
// - start-up wait of 1024 clock periods after reset or wake-up
// - calls and interrupt entries push a 2-level hidden stack; returns pop
// - call with full stack overwrites the oldest entry
`timescale 1ns/1ps
`include "pstr_cfg.svh"

module pstr_top (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// program memory
	output logic [9:0] prog_addr,
	input wire logic [13:0] prog_data,
	// core side
	output logic [1:0] phase,
	output logic [13:0] exec_word,
	output logic exec_valid,
	input wire pstr_pkg::pstr_ctl_type exec_ctl,
	output pstr_pkg::pstr_tab_type table_low,
	// interrupt requests, acknowledges and wake-up
	input wire pstr_pkg::pstr_irq_type irq_req,
	output pstr_pkg::pstr_irq_type irq_ack,
	input wire logic wake
);

	// decode of a bus word address into a register index match
	function automatic logic reg_hit(input logic [31:0] addr, input logic [9:0] idx);
		reg_hit = (addr[11:2] == idx) && (addr[31:12] == 20'h00000);
	endfunction : reg_hit

	// sequencer state
	pstr_pkg::pstr_state_type state_r, state_nxt;
	logic [1:0] phase_r, phase_nxt;
	logic [10:0] sst_cnt_r, sst_cnt_nxt;
	logic [9:0] pc_r, pc_nxt;
	logic [9:0] prog_addr_r, prog_addr_nxt;
	logic [13:0] exec_word_r, exec_word_nxt;
	logic exec_valid_r, exec_valid_nxt;
	logic [13:0] hold_word_r, hold_word_nxt;
	logic [9:0] stk_r [0:1];
	logic [9:0] stk_nxt [0:1];
	logic [1:0] depth_r, depth_nxt;
	logic [7:0] upper_r, upper_nxt;
	pstr_pkg::pstr_tab_type tab_r, tab_nxt;
	pstr_pkg::pstr_irq_type ack_r, ack_nxt;
	logic irq_take;
	logic jlb_apply;

	// bus and register state
	logic [7:0] ptr_r, ptr_nxt;
	logic [2:0] ctrl_r, ctrl_nxt;
	logic jlb_pend_r, jlb_pend_nxt;
	logic [7:0] jlb_val_r, jlb_val_nxt;
	logic wr_pend_r, wr_pend_nxt;
	logic [31:0] wr_addr_r, wr_addr_nxt;
	logic [31:0] hrdata_r, hrdata_nxt;
	logic hreadyout_r;
	logic hresp_r;

	always_comb
	begin
		logic redirect;
		logic stack_room;
		logic [9:0] ret_addr;
		redirect = 1'b0;
		stack_room = (depth_r < `PSTR_STACK_LEVELS);
		ret_addr = pc_r;
		state_nxt = state_r;
		phase_nxt = phase_r;
		sst_cnt_nxt = sst_cnt_r;
		pc_nxt = pc_r;
		prog_addr_nxt = prog_addr_r;
		exec_word_nxt = exec_word_r;
		exec_valid_nxt = exec_valid_r;
		hold_word_nxt = hold_word_r;
		stk_nxt[0] = stk_r[0];
		stk_nxt[1] = stk_r[1];
		depth_nxt = depth_r;
		upper_nxt = upper_r;
		tab_nxt = '0;
		ack_nxt = '0;
		irq_take = 1'b0;
		jlb_apply = 1'b0;
		case (state_r)
			pstr_pkg::PSTR_S_START:
			begin
				// no execution until the start-up count has run out
				sst_cnt_nxt = 11'(sst_cnt_r + 11'h001);
				exec_valid_nxt = 1'b0;
				phase_nxt = 2'h0;
				prog_addr_nxt = pc_r;
				if (sst_cnt_r == 11'(`PSTR_SST_PERIODS - 11'h001))
				begin
					state_nxt = pstr_pkg::PSTR_S_RUN;
				end
			end
			pstr_pkg::PSTR_S_RUN:
			begin
				phase_nxt = 2'(phase_r + 2'h1);
				if (phase_r == `PSTR_LAST_PHASE)
				begin
					// word fetched this cycle moves to execute, counter advances
					exec_word_nxt = prog_data;
					exec_valid_nxt = 1'b1;
					pc_nxt = 10'(pc_r + 10'h001);
					if (exec_valid_r)
					begin
						case (exec_ctl.kind)
							pstr_pkg::PSTR_K_SKIP:
							begin
								exec_valid_nxt = 1'b0;
								redirect = 1'b1;
							end
							pstr_pkg::PSTR_K_JUMP:
							begin
								pc_nxt = exec_ctl.target;
								exec_valid_nxt = 1'b0;
								redirect = 1'b1;
							end
							pstr_pkg::PSTR_K_CALL:
							begin
								// return lands on the word being prefetched now
								if (depth_r == `PSTR_STACK_LEVELS)
								begin
									stk_nxt[0] = stk_r[1];
									stk_nxt[1] = pc_r;
								end
								else
								begin
									stk_nxt[depth_r[0]] = pc_r;
									depth_nxt = 2'(depth_r + 2'h1);
								end
								pc_nxt = exec_ctl.target;
								exec_valid_nxt = 1'b0;
								redirect = 1'b1;
							end
							pstr_pkg::PSTR_K_RET:
							begin
								if (depth_r != 2'h0)
								begin
									ret_addr = stk_r[1'(depth_r - 2'h1)];
									depth_nxt = 2'(depth_r - 2'h1);
								end
								else
								begin
									ret_addr = stk_r[0];
								end
								pc_nxt = ret_addr;
								exec_valid_nxt = 1'b0;
								redirect = 1'b1;
							end
							pstr_pkg::PSTR_K_TAB_CUR, pstr_pkg::PSTR_K_TAB_FIN:
							begin
								// second cycle reads the table word, fetch is parked
								hold_word_nxt = prog_data;
								exec_valid_nxt = 1'b0;
								state_nxt = pstr_pkg::PSTR_S_TABLE;
								redirect = 1'b1;
							end
							pstr_pkg::PSTR_K_HALT:
							begin
								// refetch the discarded word after wake-up
								pc_nxt = pc_r;
								exec_valid_nxt = 1'b0;
								state_nxt = pstr_pkg::PSTR_S_HALT;
								redirect = 1'b1;
							end
							default:
							begin
								redirect = 1'b0;
							end
						endcase
					end
					if (!redirect && jlb_pend_r)
					begin
						pc_nxt = {pc_r[9:8], jlb_val_r};
						exec_valid_nxt = 1'b0;
						jlb_apply = 1'b1;
					end
					else if (!redirect && ctrl_r[`PSTR_CTRL_MASTER_EN] && stack_room)
					begin
						// interrupt entry: prefetched word is dropped and becomes the return
						if (irq_req.ext && ctrl_r[`PSTR_CTRL_EXT_EN])
						begin
							pc_nxt = `PSTR_VEC_EXT;
							ack_nxt.ext = 1'b1;
							irq_take = 1'b1;
						end
						else if (irq_req.tmr && ctrl_r[`PSTR_CTRL_TMR_EN])
						begin
							pc_nxt = `PSTR_VEC_TMR;
							ack_nxt.tmr = 1'b1;
							irq_take = 1'b1;
						end
						if (irq_take)
						begin
							stk_nxt[depth_r[0]] = pc_r;
							depth_nxt = 2'(depth_r + 2'h1);
							exec_valid_nxt = 1'b0;
						end
					end
					if (state_nxt == pstr_pkg::PSTR_S_TABLE)
					begin
						if (exec_ctl.kind == pstr_pkg::PSTR_K_TAB_FIN)
						begin
							prog_addr_nxt = {`PSTR_FINAL_PAGE, ptr_r};
						end
						else
						begin
							prog_addr_nxt = {pc_r[9:8], ptr_r};
						end
					end
					else
					begin
						prog_addr_nxt = pc_nxt;
					end
				end
			end
			pstr_pkg::PSTR_S_TABLE:
			begin
				phase_nxt = 2'(phase_r + 2'h1);
				if (phase_r == `PSTR_LAST_PHASE)
				begin
					tab_nxt.strobe = 1'b1;
					tab_nxt.low = prog_data[7:0];
					upper_nxt = {2'b00, prog_data[13:8]};
					exec_word_nxt = hold_word_r;
					exec_valid_nxt = 1'b1;
					prog_addr_nxt = pc_r;
					state_nxt = pstr_pkg::PSTR_S_RUN;
				end
			end
			pstr_pkg::PSTR_S_HALT:
			begin
				exec_valid_nxt = 1'b0;
				phase_nxt = 2'h0;
				if (wake)
				begin
					sst_cnt_nxt = 11'h000;
					state_nxt = pstr_pkg::PSTR_S_START;
				end
			end
			default:
			begin
				state_nxt = pstr_pkg::PSTR_S_START;
			end
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			state_r <= pstr_pkg::PSTR_S_START;
			phase_r <= 2'h0;
			sst_cnt_r <= 11'h000;
			pc_r <= `PSTR_VEC_RESET;
			prog_addr_r <= `PSTR_VEC_RESET;
			exec_word_r <= `PSTR_RST_WORD;
			exec_valid_r <= 1'b0;
			hold_word_r <= `PSTR_RST_WORD;
			stk_r[0] <= `PSTR_VEC_RESET;
			stk_r[1] <= `PSTR_VEC_RESET;
			depth_r <= 2'h0;
			upper_r <= `PSTR_RST_UPPER;
			tab_r <= '0;
			ack_r <= '0;
		end
		else
		begin
			state_r <= state_nxt;
			phase_r <= phase_nxt;
			sst_cnt_r <= sst_cnt_nxt;
			pc_r <= pc_nxt;
			prog_addr_r <= prog_addr_nxt;
			exec_word_r <= exec_word_nxt;
			exec_valid_r <= exec_valid_nxt;
			hold_word_r <= hold_word_nxt;
			stk_r[0] <= stk_nxt[0];
			stk_r[1] <= stk_nxt[1];
			depth_r <= depth_nxt;
			upper_r <= upper_nxt;
			tab_r <= tab_nxt;
			ack_r <= ack_nxt;
		end
	end

	always_comb
	begin
		logic take;
		take = hsel && htrans[1] && hready;
		wr_pend_nxt = take && hwrite;
		wr_addr_nxt = take ? haddr : wr_addr_r;
		ptr_nxt = ptr_r;
		ctrl_nxt = ctrl_r;
		jlb_val_nxt = jlb_val_r;
		jlb_pend_nxt = jlb_pend_r && !jlb_apply;
		if (irq_take)
		begin
			ctrl_nxt[`PSTR_CTRL_MASTER_EN] = 1'b0;
		end
		if (wr_pend_r)
		begin
			if (reg_hit(wr_addr_r, `PSTR_IDX_JUMP_LOW))
			begin
				jlb_val_nxt = hwdata[7:0];
				jlb_pend_nxt = 1'b1;
			end
			if (reg_hit(wr_addr_r, `PSTR_IDX_LOOKUP_PTR))
			begin
				ptr_nxt = hwdata[7:0];
			end
			if (reg_hit(wr_addr_r, `PSTR_IDX_CTRL))
			begin
				ctrl_nxt = hwdata[2:0];
			end
		end
		// read data is formed in the address phase so the slave never waits
		hrdata_nxt = 32'h00000000;
		if (take && !hwrite)
		begin
			if (reg_hit(haddr, `PSTR_IDX_JUMP_LOW))
			begin
				hrdata_nxt = {24'h000000, pc_r[7:0]};
			end
			else if (reg_hit(haddr, `PSTR_IDX_LOOKUP_PTR))
			begin
				hrdata_nxt = {24'h000000, ptr_r};
			end
			else if (reg_hit(haddr, `PSTR_IDX_UPPER_LATCH))
			begin
				hrdata_nxt = {24'h000000, upper_r};
			end
			else if (reg_hit(haddr, `PSTR_IDX_CTRL))
			begin
				hrdata_nxt = {29'h00000000, ctrl_r};
			end
			else if (reg_hit(haddr, `PSTR_IDX_STATUS))
			begin
				hrdata_nxt[9:0] = pc_r;
				hrdata_nxt[`PSTR_STAT_DEPTH_LSB +: 2] = depth_r;
				hrdata_nxt[`PSTR_STAT_RUNNING] = (state_r != pstr_pkg::PSTR_S_START)
					&& (state_r != pstr_pkg::PSTR_S_HALT);
				hrdata_nxt[`PSTR_STAT_HALTED] = (state_r == pstr_pkg::PSTR_S_HALT);
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ptr_r <= `PSTR_RST_PTR;
			ctrl_r <= `PSTR_CTRL_RST;
			jlb_pend_r <= 1'b0;
			jlb_val_r <= 8'h00;
			wr_pend_r <= 1'b0;
			wr_addr_r <= 32'h00000000;
			hrdata_r <= 32'h00000000;
			hreadyout_r <= 1'b1;
			hresp_r <= 1'b0;
		end
		else
		begin
			ptr_r <= ptr_nxt;
			ctrl_r <= ctrl_nxt;
			jlb_pend_r <= jlb_pend_nxt;
			jlb_val_r <= jlb_val_nxt;
			wr_pend_r <= wr_pend_nxt;
			wr_addr_r <= wr_addr_nxt;
			hrdata_r <= hrdata_nxt;
			hreadyout_r <= 1'b1;
			hresp_r <= 1'b0;
		end
	end

	assign hreadyout = hreadyout_r;
	assign hresp = hresp_r;
	assign hrdata = hrdata_r;
	assign prog_addr = prog_addr_r;
	assign phase = phase_r;
	assign exec_word = exec_word_r;
	assign exec_valid = exec_valid_r;
	assign table_low = tab_r;
	assign irq_ack = ack_r;

endmodule : pstr_top
